// ==== src/pec_pkg.sv ====
// Constants, types and register map of the performance event counter unit
package pec_pkg;
  // --------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_EVC = 12;
  localparam int NUM_BRK = 4;
  localparam int ADDR_W = 8;
  localparam int LOCKED_CH = 2;

  // --------------------------------------------------------------
  // Register offsets and fields
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h20;
  localparam int CTRL_OWNER_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_DONE_LSB = 4;
  localparam int STAT_HALF_LSB = 8;
  localparam int STAT_STEP_BIT = 12;

  // --------------------------------------------------------------
  // Trigger codes, reset values, responses
  // --------------------------------------------------------------
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [3:0] TRIG_GAP = 4'h7;
  localparam logic [3:0] TRIG_LOCK_A = 4'h8;
  localparam logic [3:0] TRIG_LOCK_B = 4'h9;
  localparam logic [3:0] TRIG_MAX = 4'hc;
  localparam logic [31:0] CNT_RESET = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    item_disabled, item_elapsed_cycles, item_privileged_cycles,
    item_block_bit_cycles, item_instructions, item_dual_issue,
    item_uncond_branches, item_exceptions_taken, item_interrupts_taken,
    item_break_channel_hits
  } pec_item_t;

  typedef enum logic [1:0] {ph_idle, ph_armed, ph_counting, ph_done} pec_phase_t;

  typedef struct packed {
    logic [3:0] channel_end_trigger_sel;
    logic [3:0] channel_start_trigger_sel;
    pec_item_t item;
  } pec_cfg_t;

  typedef struct packed {
    logic power_on_period;
    logic privileged_mode;
    logic status_block_bit;
    logic insn_complete;
    logic dual_issue;
    logic uncond_branch;
    logic exc_entry_branch;
    logic return_from_exception;
    logic exception_taken;
    logic interrupt_taken;
    logic nmi_taken;
    logic [NUM_BRK-1:0] break_hit;
    logic exec_start;
    logic [NUM_EVC-1:0] event_cond;
  } pec_cpu_ev_t;

  typedef struct packed {
    pec_phase_t phase;
    logic [31:0] count;
  } pec_ch_state_t;
endpackage

// ==== src/pec_channel.sv ====
// One counting channel: trigger gating, item selection and counter
`timescale 1ns/1ps
module pec_channel (
  input logic aclk,
  input logic aresetn,
  input logic enable,
  input logic restart,
  input pec_pkg::pec_cfg_t cfg,
  input pec_pkg::pec_cpu_ev_t ev,
  output logic [31:0] count,
  output pec_pkg::pec_phase_t phase
);
  pec_pkg::pec_ch_state_t s;
  pec_pkg::pec_ch_state_t next_s;
  logic free_mode;
  logic gated_mode;
  logic start_hit;
  logic end_hit;
  logic [1:0] incr;

  function automatic logic trig_hit(logic [3:0] sel, pec_pkg::pec_cpu_ev_t e);
    logic hit;
    hit = 1'b0;
    if (sel != pec_pkg::TRIG_NONE && sel <= pec_pkg::TRIG_MAX)
    begin
      hit = e.event_cond[sel - 4'h1];
    end
    return hit;
  endfunction

  function automatic logic [1:0] item_incr(pec_pkg::pec_item_t item,
                                           pec_pkg::pec_cpu_ev_t e);
    logic live;
    logic [1:0] v;
    live = !e.power_on_period;
    case (item)
      pec_pkg::item_elapsed_cycles: v = {1'b0, live}; // see [R8]
      pec_pkg::item_privileged_cycles: v = {1'b0, live & e.privileged_mode}; // see [R9]
      pec_pkg::item_block_bit_cycles: v = {1'b0, live & e.status_block_bit}; // see [R10]
      pec_pkg::item_instructions: v = {1'b0, e.insn_complete} + {1'b0, e.dual_issue}; // see [R11]
      pec_pkg::item_dual_issue: v = {1'b0, e.dual_issue}; // see [R12]
      pec_pkg::item_uncond_branches:
        v = {1'b0, (e.uncond_branch & !e.exc_entry_branch) | e.return_from_exception}; // see [R13]
      pec_pkg::item_exceptions_taken:
        v = {1'b0, e.exception_taken | e.interrupt_taken | e.nmi_taken}; // see [R14]
      pec_pkg::item_interrupts_taken: v = {1'b0, e.interrupt_taken | e.nmi_taken}; // see [R15]
      pec_pkg::item_break_channel_hits: v = {1'b0, |e.break_hit}; // see [R16]
      default: v = 2'h0; // see [R17]
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    free_mode = cfg.channel_start_trigger_sel == pec_pkg::TRIG_NONE &&
                cfg.channel_end_trigger_sel == pec_pkg::TRIG_NONE;
    gated_mode = cfg.channel_start_trigger_sel != pec_pkg::TRIG_NONE &&
                 cfg.channel_end_trigger_sel != pec_pkg::TRIG_NONE;
    start_hit = free_mode ? ev.exec_start : trig_hit(cfg.channel_start_trigger_sel, ev); // see [R4]
    end_hit = free_mode ? |ev.event_cond : trig_hit(cfg.channel_end_trigger_sel, ev); // see [R2]
    incr = item_incr(cfg.item, ev);
    case (s.phase)
      pec_pkg::ph_idle: next_s.phase = pec_pkg::ph_idle;
      pec_pkg::ph_armed:
        if (start_hit)
        begin
          next_s.phase = pec_pkg::ph_counting;
        end
      pec_pkg::ph_counting:
        if (end_hit)
        begin
          next_s.phase = pec_pkg::ph_done;
        end
        else
        begin
          next_s.count = s.count + {30'h0, incr};
        end
      pec_pkg::ph_done: next_s.phase = pec_pkg::ph_done; // see [R17]
      default: next_s.phase = pec_pkg::ph_idle;
    endcase
    // Only one trigger selected leaves the channel idle
    if (restart)
    begin
      next_s.count = pec_pkg::CNT_RESET;
      next_s.phase = (free_mode || gated_mode) ? pec_pkg::ph_armed : pec_pkg::ph_idle; // see [R5]
    end
    if (!enable)
    begin
      next_s.phase = pec_pkg::ph_idle;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '{phase: pec_pkg::ph_idle, count: pec_pkg::CNT_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign phase = s.phase;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ELAPSED_STEP: assert property ( // see [R8]
    s.phase == pec_pkg::ph_counting && !end_hit && !restart && enable &&
    cfg.item == pec_pkg::item_elapsed_cycles && !ev.power_on_period
    |=> s.count == $past(s.count) + 32'h1)
    else $error("elapsed item did not step by one");
  AST_PRIV_GATE: assert property ( // see [R9]
    s.phase == pec_pkg::ph_counting && !restart &&
    cfg.item == pec_pkg::item_privileged_cycles && !ev.privileged_mode
    |=> $stable(s.count))
    else $error("privileged item counted outside privileged mode");
  AST_DUAL_ADDS_TWO: assert property ( // see [R11]
    s.phase == pec_pkg::ph_counting && !end_hit && !restart && enable &&
    cfg.item == pec_pkg::item_instructions && ev.insn_complete && ev.dual_issue
    |=> s.count == $past(s.count) + 32'h2)
    else $error("dual completion did not add two");
  AST_BREAK_OR: assert property ( // see [R16]
    s.phase == pec_pkg::ph_counting && !end_hit && !restart && enable &&
    cfg.item == pec_pkg::item_break_channel_hits && |ev.break_hit
    |=> s.count == $past(s.count) + 32'h1)
    else $error("break hit not counted once");
  AST_DISABLED_STILL: assert property ( // see [R17]
    cfg.item == pec_pkg::item_disabled && !restart |=> $stable(s.count))
    else $error("disabled channel moved");
  AST_DONE_HOLDS: assert property ( // see [R17]
    s.phase == pec_pkg::ph_done && !restart && enable
    |=> s.phase == pec_pkg::ph_done && $stable(s.count))
    else $error("finished channel did not hold");
  AST_FREE_STOP: assert property ( // see [R4]
    s.phase == pec_pkg::ph_counting && free_mode && |ev.event_cond && !restart && enable
    |=> s.phase == pec_pkg::ph_done)
    else $error("free channel did not stop on event");
  AST_GATED_START: assert property ( // see [R2]
    s.phase == pec_pkg::ph_armed && gated_mode && start_hit && !restart && enable
    |=> s.phase == pec_pkg::ph_counting && s.count == pec_pkg::CNT_RESET)
    else $error("gated channel missed start");
endmodule

// ==== src/pec_top.sv ====
// Performance event counter unit with AXI4-Lite register access
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
// Contract
// [R1] Four channels count concurrently, independently
// [R2] Start and end triggers from condition channels
// [R3] Channels one, two refuse conditions eight, nine
// [R4] No triggers: run from execution to event
// [R5] Host must select both triggers or none
// [R6] Selected triggers make single-step unavailable
// [R7] User ownership locks channels one and two
// [R8] Elapsed item counts cycles outside power-on
// [R9] Privileged item counts privileged-mode cycles
// [R10] Block-bit item counts cycles with bit set
// [R11] Instruction item counts dual completions twice
// [R12] Dual-issue item counts simultaneous pairs
// [R13] Branch item skips exception entry, counts returns
// [R14] Exception item includes accepted interrupts
// [R15] Interrupt item includes non-maskable interrupt
// [R16] Break item ORs all break channel hits
// [R17] Disabled item idles; finished channel holds value
module pec_top (
  input logic aclk,
  input logic aresetn,
  input logic [pec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [pec_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input pec_pkg::pec_cpu_ev_t cpu_ev,
  output logic single_step_inhibit
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [pec_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic counter_owner_select;
    pec_pkg::pec_cfg_t [pec_pkg::NUM_CH-1:0] cfg;
    logic [pec_pkg::NUM_CH-1:0] restart;
    logic step_inhibit;
  } pec_top_state_t;

  pec_top_state_t s;
  pec_top_state_t next_s;
  logic [31:0] ch_count [pec_pkg::NUM_CH];
  pec_pkg::pec_phase_t ch_phase [pec_pkg::NUM_CH];
  logic [1:0] widx;
  logic [1:0] ridx;
  logic [31:0] merged;
  pec_pkg::pec_cfg_t new_cfg;
  logic any_gated;
  logic [pec_pkg::NUM_CH-1:0] run_v;
  logic [pec_pkg::NUM_CH-1:0] done_v;
  logic [pec_pkg::NUM_CH-1:0] half_v;

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function automatic logic in_bank(logic [pec_pkg::ADDR_W-1:0] a,
                                   logic [pec_pkg::ADDR_W-1:0] base);
    return a[7:4] == base[7:4] && a[1:0] == 2'h0;
  endfunction

  function automatic logic ch_blocked(logic [1:0] idx, logic owner_user);
    return owner_user && ({30'h0, idx} < 32'(pec_pkg::LOCKED_CH)); // see [R7]
  endfunction

  function automatic logic trig_ok(logic [1:0] idx, logic [3:0] sel);
    logic ok;
    ok = sel <= pec_pkg::TRIG_MAX && sel != pec_pkg::TRIG_GAP; // see [R2]
    if ({30'h0, idx} < 32'(pec_pkg::LOCKED_CH) &&
        (sel == pec_pkg::TRIG_LOCK_A || sel == pec_pkg::TRIG_LOCK_B))
    begin
      ok = 1'b0; // see [R3]
    end
    return ok;
  endfunction

  function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] nw,
                                             logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // Register file and bus slave
  // --------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.restart = '0;
    widx = s.waddr[3:2];
    ridx = s_axi_araddr[3:2];
    merged = lane_merge({20'h0, s.cfg[widx]}, s.wdata, s.wstrb);
    new_cfg = pec_pkg::pec_cfg_t'(merged[11:0]);
    any_gated = 1'b0;
    for (int i = 0; i < pec_pkg::NUM_CH; i++)
    begin
      run_v[i] = ch_phase[i] == pec_pkg::ph_counting;
      done_v[i] = ch_phase[i] == pec_pkg::ph_done;
      half_v[i] = (s.cfg[i].channel_start_trigger_sel == pec_pkg::TRIG_NONE) !=
                  (s.cfg[i].channel_end_trigger_sel == pec_pkg::TRIG_NONE);
      if (s.cfg[i].channel_start_trigger_sel != pec_pkg::TRIG_NONE &&
          s.cfg[i].channel_end_trigger_sel != pec_pkg::TRIG_NONE)
      begin
        any_gated = 1'b1;
      end
    end
    next_s.step_inhibit = any_gated; // see [R6]
    // Write side: address and data may come in either order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_got = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = pec_pkg::RESP_OKAY;
      if (s.waddr == pec_pkg::OFS_CTRL)
      begin
        if (s.wstrb[0])
        begin
          next_s.counter_owner_select = s.wdata[pec_pkg::CTRL_OWNER_BIT];
          if (s.wdata[pec_pkg::CTRL_RESTART_BIT])
          begin
            next_s.restart = '1;
          end
        end
      end
      else if (in_bank(s.waddr, pec_pkg::OFS_CFG0))
      begin
        if (ch_blocked(widx, s.counter_owner_select) || // see [R7]
            !trig_ok(widx, new_cfg.channel_start_trigger_sel) ||
            !trig_ok(widx, new_cfg.channel_end_trigger_sel) ||
            new_cfg.item > pec_pkg::item_break_channel_hits)
        begin
          next_s.bresp = pec_pkg::RESP_SLVERR; // see [R3]
        end
        else
        begin
          next_s.cfg[widx] = new_cfg;
          next_s.restart[widx] = 1'b1;
        end
      end
      else
      begin
        next_s.bresp = pec_pkg::RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
    end
    // Read side: data ready one cycle after the address
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = pec_pkg::RESP_OKAY;
      next_s.rdata = 32'h0;
      if (s_axi_araddr == pec_pkg::OFS_CTRL)
      begin
        next_s.rdata[pec_pkg::CTRL_OWNER_BIT] = s.counter_owner_select;
      end
      else if (s_axi_araddr == pec_pkg::OFS_STATUS)
      begin
        next_s.rdata[pec_pkg::STAT_RUN_LSB +: pec_pkg::NUM_CH] = run_v;
        next_s.rdata[pec_pkg::STAT_DONE_LSB +: pec_pkg::NUM_CH] = done_v;
        next_s.rdata[pec_pkg::STAT_HALF_LSB +: pec_pkg::NUM_CH] = half_v;
        next_s.rdata[pec_pkg::STAT_STEP_BIT] = s.step_inhibit;
      end
      else if (in_bank(s_axi_araddr, pec_pkg::OFS_CFG0))
      begin
        next_s.rdata[11:0] = s.cfg[ridx];
      end
      else if (in_bank(s_axi_araddr, pec_pkg::OFS_CNT0))
      begin
        if (!ch_blocked(ridx, s.counter_owner_select))
        begin
          next_s.rdata = ch_count[ridx]; // see [R7]
        end
      end
      else
      begin
        next_s.rresp = pec_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------
  // Counting channels
  // --------------------------------------------------------------
  for (genvar g = 0; g < pec_pkg::NUM_CH; g++)
  begin : g_ch
    pec_channel u_ch ( // see [R1]
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(!ch_blocked(2'(g), s.counter_owner_select)),
      .restart(s.restart[g]),
      .cfg(s.cfg[g]),
      .ev(cpu_ev),
      .count(ch_count[g]),
      .phase(ch_phase[g])
    );
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign single_step_inhibit = s.step_inhibit;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STEP_BLOCK: assert property ( // see [R6]
    any_gated ##1 any_gated |-> single_step_inhibit)
    else $error("single-step not blocked with triggers set");
  AST_OWNER_LOCK: assert property ( // see [R7]
    s.arready && s_axi_arvalid && s.counter_owner_select &&
    s_axi_araddr == pec_pkg::OFS_CNT0
    |=> s.rvalid && s.rdata == 32'h0)
    else $error("locked channel count visible");
  AST_LOCKED_TRIG: assert property ( // see [R3]
    s.aw_got && s.w_got && !s.bvalid && s.waddr == pec_pkg::OFS_CFG0 &&
    s.wstrb[0] && s.wdata[7:4] == pec_pkg::TRIG_LOCK_A
    |=> s.bvalid && s.bresp == pec_pkg::RESP_SLVERR && s.cfg[0] == $past(s.cfg[0]))
    else $error("channel one accepted condition eight");
  AST_CFG_RESTART: assert property ( // see [R2]
    s.aw_got && s.w_got && !s.bvalid && next_s.restart[1] && !next_s.restart[0]
    |=> ##1 ch_count[1] == pec_pkg::CNT_RESET)
    else $error("configured channel not cleared");
endmodule

// ==== verification/pec_cpu_model.sv ====
// CPU event source model that plays measurement windows
`timescale 1ns/1ps
module pec_cpu_model (
  input logic aclk,
  input logic go,
  input logic free,
  input logic [7:0] n,
  input pec_pkg::pec_cpu_ev_t act,
  output pec_pkg::pec_cpu_ev_t cpu_ev
);
  logic busy = 1'b0;
  logic [7:0] k = 8'h00;
  initial
  begin
    cpu_ev = '0;
  end
  // Start pulse, n cycles with act on odd ones, end pulse
  always @(posedge aclk)
  begin
    cpu_ev <= '0;
    if (go && !busy)
    begin
      busy <= 1'b1;
      k <= 8'h00;
      if (free)
        cpu_ev.exec_start <= 1'b1;
      else
        cpu_ev.event_cond[0] <= 1'b1;
    end
    else if (busy && k < n)
    begin
      if (k[0])
        cpu_ev <= act;
      k <= k + 8'h01;
    end
    else if (busy)
    begin
      // Free mode ends on an arbitrary condition channel
      if (free)
        cpu_ev.event_cond[5] <= 1'b1;
      else
        cpu_ev.event_cond[1] <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench of the performance event counter unit
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  // Response readies stay high: the bench never stalls an answer
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic go = 1'b0;
  logic free = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, inhibit;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  pec_pkg::pec_cpu_ev_t act = '0;
  pec_pkg::pec_cpu_ev_t cpu_ev, ev;
  int err_total = 0;
  int n_compared = 0;

  always #12.5 aclk = ~aclk;

  pec_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_ev(cpu_ev), .single_step_inhibit(inhibit));

  pec_cpu_model u_cpu (.aclk(aclk), .go(go), .free(free), .n(8'd20), .act(act),
    .cpu_ev(cpu_ev));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] cfg_a(input int i);
    return pec_pkg::OFS_CFG0 + 8'(4 * i);
  endfunction

  function automatic logic [7:0] cnt_a(input int i);
    return pec_pkg::OFS_CNT0 + 8'(4 * i);
  endfunction

  task wrchk(input logic [7:0] a, input logic [31:0] v, input logic e);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    check({30'h0, r}, {30'h0, e ? pec_pkg::RESP_SLVERR : pec_pkg::RESP_OKAY});
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    check(d, exp);
    check({30'h0, r}, {30'h0, e ? pec_pkg::RESP_SLVERR : pec_pkg::RESP_OKAY});
  endtask

  task window(input logic f);
    repeat (2) @(posedge aclk);
    go <= 1'b1;
    free <= f;
    @(posedge aclk);
    go <= 1'b0;
    repeat (26) @(posedge aclk);
  endtask

  task run_group(input logic [3:0] it [4], input pec_pkg::pec_cpu_ev_t a,
    input logic [31:0] e [4]);
    for (int i = 0; i < 4; i++)
      wrchk(cfg_a(i), 32'h210 | {28'h0, it[i]}, 1'b0);
    act <= a;
    window(1'b0);
    for (int i = 0; i < 4; i++)
      rdchk(cnt_a(i), e[i], 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rdchk(cfg_a(0), 32'h0, 1'b0);
    rdchk(pec_pkg::OFS_STATUS, 32'h0, 1'b0);
    rdchk(cnt_a(3), 32'h0, 1'b0);
    check({31'h0, inhibit}, 32'h0);
  endtask

  task t_refuse;
    wrchk(cfg_a(0), 32'h981, 1'b1);
    wrchk(cfg_a(1), 32'h181, 1'b1);
    wrchk(cfg_a(1), 32'h171, 1'b1);
    wrchk(cfg_a(3), 32'hd11, 1'b1);
    wrchk(cnt_a(0), 32'h1, 1'b1);
    rdchk(cfg_a(0), 32'h0, 1'b0);
    rdchk(8'hfc, 32'h0, 1'b1);
    wrchk(cfg_a(2), 32'hc98, 1'b0);
    repeat (2) @(posedge aclk);
    check({31'h0, inhibit}, 32'h1);
    rdchk(pec_pkg::OFS_STATUS, 32'h1000, 1'b0);
  endtask

  task t_half;
    wrchk(cfg_a(3), 32'h011, 1'b0);
    rdchk(pec_pkg::OFS_STATUS, 32'h1800, 1'b0);
    window(1'b0);
    rdchk(cnt_a(3), 32'h0, 1'b0);
  endtask

  task t_groups;
    ev = '0;
    ev.power_on_period = 1'b1;
    ev.break_hit = 4'h1;
    ev.uncond_branch = 1'b1;
    ev.return_from_exception = 1'b1;
    run_group('{4'h1, 4'h9, 4'h6, 4'h0}, ev, '{32'ha, 32'ha, 32'ha, 32'h0});
    ev = '0;
    ev.insn_complete = 1'b1;
    ev.dual_issue = 1'b1;
    ev.nmi_taken = 1'b1;
    run_group('{4'h4, 4'h5, 4'h7, 4'h8}, ev, '{32'h14, 32'ha, 32'ha, 32'ha});
    window(1'b0);
    rdchk(cnt_a(0), 32'h14, 1'b0);
    ev = '0;
    ev.privileged_mode = 1'b1;
    ev.status_block_bit = 1'b1;
    ev.uncond_branch = 1'b1;
    ev.exc_entry_branch = 1'b1;
    ev.interrupt_taken = 1'b1;
    run_group('{4'h2, 4'h3, 4'h6, 4'h7}, ev, '{32'ha, 32'ha, 32'h0, 32'ha});
  endtask

  task t_free;
    for (int i = 1; i < 4; i++)
      wrchk(cfg_a(i), 32'h0, 1'b0);
    wrchk(cfg_a(0), 32'h1, 1'b0);
    repeat (2) @(posedge aclk);
    check({31'h0, inhibit}, 32'h0);
    act <= '0;
    window(1'b1);
    rdchk(cnt_a(0), 32'h14, 1'b0);
  endtask

  task t_owner;
    wrchk(pec_pkg::OFS_CTRL, 32'h1, 1'b0);
    rdchk(pec_pkg::OFS_CTRL, 32'h1, 1'b0);
    wrchk(cfg_a(0), 32'h1, 1'b1);
    rdchk(cnt_a(0), 32'h0, 1'b0);
    wrchk(cfg_a(2), 32'h1, 1'b0);
    wrchk(pec_pkg::OFS_CTRL, 32'h0, 1'b0);
    rdchk(cnt_a(0), 32'h14, 1'b0);
    wrchk(pec_pkg::OFS_CTRL, 32'h2, 1'b0);
    rdchk(cnt_a(0), 32'h0, 1'b0);
  endtask

  task test_done;
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_refuse;
    t_half;
    t_groups;
    t_free;
    t_owner;
    test_done;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_total++;
    test_done;
  end
endmodule
